// ### src/sfbc_dev.sv
// device end: frequency word, bit-rate divider, clock output and start-up sequencer
//
// Chosen here: the Avalon-MM register port.
`timescale 1ns/10ps
module sfbc_dev #(
    parameter int OSC_CYC    = sfbc_pkg::OSC_START_CYC,
    parameter int COARSE_CYC = sfbc_pkg::COARSE_CYC,
    parameter int FINE_CYC   = sfbc_pkg::FINE_CYC,
    parameter int LOCK_CYC   = sfbc_pkg::LOCK_CYC
) (
    input  wire logic  clk,
    input  wire logic  rst,
    sfbc_link_if.dev   link,
    output logic [23:0] synth_freq_q,
    output logic       osc_ready_q,
    output logic       coarse_cal_q,
    output logic       fine_cal_q,
    output logic       synth_en_q,
    output logic       rx_en_q,
    output logic       tx_en_q,
    output logic       ext_ref_q,
    output logic       bit_tick_q,
    output logic       tx_bit_q
);
    typedef enum logic [2:0] {S_OSC, S_COARSE, S_IDLE, S_FINE, S_LOCK, S_LOCKED} sfbc_dev_st_t;

    sfbc_dev_st_t st_q;
    logic [15:0]  cnt_q;
    logic [7:0]   opmode_q;
    logic [7:0]   datamode_q;
    logic [15:0]  br_q;
    logic [7:0]   frf_hi_q;
    logic [7:0]   frf_mid_q;
    logic [7:0]   iomap_q;
    logic [7:0]   refsel_q;
    logic [7:0]   rdata_q;
    logic         rvalid_q;
    logic         lock_q;
    logic         lock_pin_q;
    logic         clk_out_q;
    logic [7:0]   div_q;
    logic [15:0]  brc_q;
    logic         data_bit_clock_q;
    logic         sd_m_q;
    logic         sd_s_q;
    logic [2:0]   mode;
    logic [2:0]   clk_sel;
    logic         seq_on;
    logic         synth_req;
    logic         frf_apply;
    logic         cont;
    logic         shaped;
    logic         br_active;
    logic [15:0]  br_last;
    logic [15:0]  br_half;

    function automatic logic hit(input logic [15:0] c, input int n);
        hit = (c == 16'(n - 1));
    endfunction

    assign mode      = opmode_q[sfbc_pkg::OPM_MODE_LSB +: 3];
    assign seq_on    = ~opmode_q[sfbc_pkg::OPM_SEQ_OFF];
    assign clk_sel   = iomap_q[2:0];
    assign cont      = datamode_q[sfbc_pkg::DM_CONT];
    assign shaped    = |datamode_q[1:0];
    assign synth_req = (mode == sfbc_pkg::MODE_FS) || (mode == sfbc_pkg::MODE_TX)
                       || (mode == sfbc_pkg::MODE_RX);
    assign frf_apply = link.reg_wr && (link.reg_addr == sfbc_pkg::A_FRF_LSB);
    assign br_last   = (br_q < 16'h0002) ? 16'h0001 : br_q - 16'h0001;
    assign br_half   = br_q >> 1;
    assign br_active = tx_en_q && (!cont || shaped);

    assign link.reg_rdata   = rdata_q;
    assign link.reg_rvalid  = rvalid_q;
    assign link.data_clock  = data_bit_clock_q;
    assign link.io_pin_five = clk_out_q;
    assign link.lock_detect = lock_pin_q;

    // register writes; the frequency bytes above the low byte only stage
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            opmode_q   <= sfbc_pkg::OPMODE_RST;
            datamode_q <= sfbc_pkg::DATAMODE_RST;
            br_q       <= sfbc_pkg::BR_RST;
            frf_hi_q   <= sfbc_pkg::FRF_RST[23:16];
            frf_mid_q  <= sfbc_pkg::FRF_RST[15:8];
            iomap_q    <= sfbc_pkg::IOMAP2_RST;
            refsel_q   <= sfbc_pkg::REFSEL_RST;
        end else if (link.reg_wr) begin
            unique case (link.reg_addr)
                sfbc_pkg::A_OPMODE:   opmode_q   <= link.reg_wdata;
                sfbc_pkg::A_DATAMODE: datamode_q <= link.reg_wdata;
                sfbc_pkg::A_BR_MSB:   br_q[15:8] <= link.reg_wdata;
                sfbc_pkg::A_BR_LSB:   br_q[7:0]  <= link.reg_wdata;
                sfbc_pkg::A_FRF_MSB:  frf_hi_q   <= link.reg_wdata;
                sfbc_pkg::A_FRF_MID:  frf_mid_q  <= link.reg_wdata;
                sfbc_pkg::A_IOMAP2:   iomap_q    <= link.reg_wdata;
                sfbc_pkg::A_REFSEL:   refsel_q   <= link.reg_wdata;
                default: ;
            endcase
        end
    end

    // carrier = word * oscillator_frequency / 2^19; the analog side scales it
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            synth_freq_q <= sfbc_pkg::FRF_RST;
        end else if (frf_apply) begin
            synth_freq_q <= {frf_hi_q, frf_mid_q, link.reg_wdata};
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            ext_ref_q <= 1'b0;
        end else begin
            ext_ref_q <= refsel_q[sfbc_pkg::REF_EXT_BIT];
        end
    end

    // register reads answer one cycle later
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rdata_q  <= 8'h00;
            rvalid_q <= 1'b0;
        end else begin
            rvalid_q <= link.reg_rd;
            unique case (link.reg_addr)
                sfbc_pkg::A_OPMODE:   rdata_q <= opmode_q;
                sfbc_pkg::A_DATAMODE: rdata_q <= datamode_q;
                sfbc_pkg::A_BR_MSB:   rdata_q <= br_q[15:8];
                sfbc_pkg::A_BR_LSB:   rdata_q <= br_q[7:0];
                sfbc_pkg::A_FRF_MSB:  rdata_q <= frf_hi_q;
                sfbc_pkg::A_FRF_MID:  rdata_q <= frf_mid_q;
                sfbc_pkg::A_FRF_LSB:  rdata_q <= synth_freq_q[7:0];
                sfbc_pkg::A_IOMAP2:   rdata_q <= iomap_q;
                sfbc_pkg::A_FLAGS: begin
                    rdata_q                      <= 8'h00;
                    rdata_q[sfbc_pkg::FLAG_READY] <= osc_ready_q;
                    rdata_q[sfbc_pkg::FLAG_LOCK]  <= lock_q;
                end
                sfbc_pkg::A_REFSEL:   rdata_q <= refsel_q;
                default:              rdata_q <= 8'h00;
            endcase
        end
    end

    // start-up sequencer; a new frequency while locked forces a relock
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            st_q  <= S_OSC;
            cnt_q <= 16'h0000;
        end else begin
            cnt_q <= cnt_q + 16'h0001;
            unique case (st_q)
                S_OSC: if (hit(cnt_q, OSC_CYC)) begin
                    st_q  <= S_COARSE;
                    cnt_q <= 16'h0000;
                end
                S_COARSE: if (hit(cnt_q, COARSE_CYC)) begin
                    st_q <= S_IDLE;
                end
                S_IDLE: begin
                    cnt_q <= 16'h0000;
                    if (synth_req) begin
                        st_q <= S_FINE;
                    end
                end
                S_FINE: if (!synth_req) begin
                    st_q <= S_IDLE;
                end else if (hit(cnt_q, FINE_CYC)) begin
                    st_q  <= S_LOCK;
                    cnt_q <= 16'h0000;
                end
                S_LOCK: if (!synth_req) begin
                    st_q <= S_IDLE;
                end else if (hit(cnt_q, LOCK_CYC)) begin
                    st_q <= S_LOCKED;
                end
                S_LOCKED: begin
                    cnt_q <= 16'h0000;
                    if (!synth_req) begin
                        st_q <= S_IDLE;
                    end else if (frf_apply) begin
                        st_q <= S_LOCK;
                    end
                end
                default: st_q <= S_OSC;
            endcase
        end
    end

    // status and enables; manual mode trusts the host to wait for lock
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            osc_ready_q  <= 1'b0;
            coarse_cal_q <= 1'b0;
            fine_cal_q   <= 1'b0;
            synth_en_q   <= 1'b0;
            lock_q       <= 1'b0;
            rx_en_q      <= 1'b0;
            tx_en_q      <= 1'b0;
        end else begin
            osc_ready_q  <= (st_q != S_OSC);
            coarse_cal_q <= (st_q == S_COARSE);
            fine_cal_q   <= (st_q == S_FINE);
            synth_en_q   <= (st_q == S_FINE) || (st_q == S_LOCK) || (st_q == S_LOCKED);
            lock_q       <= (st_q == S_LOCKED);
            rx_en_q      <= (mode == sfbc_pkg::MODE_RX)
                            && (seq_on ? (st_q == S_LOCKED) : synth_en_q);
            tx_en_q      <= (mode == sfbc_pkg::MODE_TX)
                            && (seq_on ? (st_q == S_LOCKED) : synth_en_q);
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            lock_pin_q <= 1'b0;
        end else begin
            lock_pin_q <= (iomap_q[sfbc_pkg::IOMAP_LOCK_LSB +: 2] == sfbc_pkg::LOCK_MAP_ON)
                          && (st_q == S_LOCKED);
        end
    end

    // clock output: select n below 7 gives clk / 2^(n+1), select 7 is off; held low until oscillator ready and in sleep mode
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            div_q     <= 8'h00;
            clk_out_q <= 1'b0;
        end else begin
            div_q     <= div_q + 8'h01;
            clk_out_q <= osc_ready_q && (mode != sfbc_pkg::MODE_SLEEP)
                         && (clk_sel != sfbc_pkg::REFERENCE_CLOCK_OUTPUT_OFF) && div_q[clk_sel];
        end
    end

    // bit-rate divider: period br cycles (2 when br is below 2), data clock high in first half
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            brc_q      <= 16'h0000;
            bit_tick_q <= 1'b0;
            data_bit_clock_q     <= 1'b0;
        end else begin
            if (!br_active || brc_q >= br_last) begin
                brc_q <= 16'h0000;
            end else begin
                brc_q <= brc_q + 16'h0001;
            end
            bit_tick_q <= br_active && (brc_q == 16'h0000);
            data_bit_clock_q     <= br_active && cont && shaped && (brc_q < br_half);
        end
    end

    // data pin may change at any time when unshaped, so it is synchronised
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            sd_m_q <= 1'b0;
            sd_s_q <= 1'b0;
        end else begin
            sd_m_q <= link.serial_data;
            sd_s_q <= sd_m_q;
        end
    end

    // shaped: sample at the falling data clock, mid-bit
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            tx_bit_q <= 1'b0;
        end else if (cont && !shaped) begin
            tx_bit_q <= sd_s_q;
        end else if (cont && br_active && (brc_q == br_half)) begin
            tx_bit_q <= sd_s_q;
        end
    end
endmodule

// ### src/sfbc_host.sv
// host end: avalon-mm register bridge, data streaming and lock / clock watch
`timescale 1ns/10ps
module sfbc_host #(
    parameter int LOSS_FILT = sfbc_pkg::LOSS_FILT_CYC
) (
    input  wire logic        clk,
    input  wire logic        rst,
    sfbc_link_if.host        link,
    input  wire logic [4:0]  avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    output logic      [31:0] avs_readdata,
    output logic             avs_waitrequest,
    output logic             irq_q
);
    typedef enum logic {H_IDLE, H_RD} sfbc_host_st_t;

    sfbc_host_st_t           st_q;
    logic                    wr_q;
    logic                    rd_q;
    logic [6:0]              addr_q;
    logic [7:0]              wdata_q;
    logic [7:0]              last_rd_q;
    logic                    sdo_q;
    logic [7:0]              sh_q;
    logic [3:0]              scnt_q;
    logic [1:0]              ctrl_q;
    logic [sfbc_pkg::IRQ_W-1:0] irq_st_q;
    logic [sfbc_pkg::IRQ_W-1:0] irq_en_q;
    logic [sfbc_pkg::IRQ_W-1:0] ev;
    logic                    co_m_q;
    logic                    co_s_q;
    logic                    co_p_q;
    logic                    lk_m_q;
    logic                    lk_s_q;
    logic                    dc_m_q;
    logic                    dc_s_q;
    logic                    dc_p_q;
    logic                    osc_seen_q;
    logic                    lk_good_q;
    logic [7:0]              lf_q;
    logic                    acc;
    logic                    wr_hit;
    logic                    dc_rise;
    logic                    lock_drop;

    assign link.reg_wr      = wr_q;
    assign link.reg_rd      = rd_q;
    assign link.reg_addr    = addr_q;
    assign link.reg_wdata   = wdata_q;
    assign link.serial_data = sdo_q;

    assign acc       = (avs_read || avs_write) && !avs_waitrequest;
    assign wr_hit    = avs_write && !avs_waitrequest;
    assign dc_rise   = dc_s_q && !dc_p_q;
    assign lock_drop = lk_good_q && !lk_s_q && (lf_q == 8'(LOSS_FILT - 1));
    assign ev = {scnt_q == 4'h1 && dc_rise && ctrl_q[0],
                 lock_drop,
                 lk_s_q && !lk_good_q,
                 co_s_q && !co_p_q && !osc_seen_q,
                 wr_q || (st_q == H_RD && link.reg_rvalid)};

    // clock output, lock detect and data clock from the device are treated as pins
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            {co_m_q, co_s_q, co_p_q} <= 3'h0;
            {lk_m_q, lk_s_q}         <= 2'h0;
            {dc_m_q, dc_s_q, dc_p_q} <= 3'h0;
        end else begin
            {co_m_q, co_s_q, co_p_q} <= {link.io_pin_five, co_m_q, co_s_q};
            {lk_m_q, lk_s_q}         <= {link.lock_detect, lk_m_q};
            {dc_m_q, dc_s_q, dc_p_q} <= {link.data_clock, dc_m_q, dc_s_q};
        end
    end

    // clock output seen means the oscillator is up
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            osc_seen_q <= 1'b0;
        end else if (co_s_q && !co_p_q) begin
            osc_seen_q <= 1'b1;
        end
    end

    // lock gained at once, lost only after a long low spell
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            lk_good_q <= 1'b0;
            lf_q      <= 8'h00;
        end else if (lk_s_q) begin
            lk_good_q <= 1'b1;
            lf_q      <= 8'h00;
        end else if (lk_good_q) begin
            lf_q <= lf_q + 8'h01;
            if (lock_drop) begin
                lk_good_q <= 1'b0;
            end
        end
    end

    // bus slave: waitrequest drops for exactly one cycle per request
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            avs_waitrequest <= 1'b1;
            avs_readdata    <= 32'h0000_0000;
        end else begin
            avs_waitrequest <= !((avs_read || avs_write) && avs_waitrequest);
            unique case (avs_address)
                sfbc_pkg::H_STATUS: avs_readdata <= {13'h0000, dc_s_q, lk_good_q,
                                                     osc_seen_q, last_rd_q, 7'h00,
                                                     st_q == H_RD};
                sfbc_pkg::H_IRQ_ST: avs_readdata <= 32'(irq_st_q);
                sfbc_pkg::H_IRQ_EN: avs_readdata <= 32'(irq_en_q);
                sfbc_pkg::H_STREAM: avs_readdata <= 32'(scnt_q);
                sfbc_pkg::H_CTRL:   avs_readdata <= 32'(ctrl_q);
                default:            avs_readdata <= 32'h0000_0000;
            endcase
        end
    end

    // device register commands; a command while busy is dropped
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            st_q      <= H_IDLE;
            wr_q      <= 1'b0;
            rd_q      <= 1'b0;
            addr_q    <= 7'h00;
            wdata_q   <= 8'h00;
            last_rd_q <= 8'h00;
        end else begin
            wr_q <= 1'b0;
            rd_q <= 1'b0;
            if (st_q == H_RD) begin
                if (link.reg_rvalid) begin
                    last_rd_q <= link.reg_rdata;
                    st_q      <= H_IDLE;
                end
            end else if (wr_hit && avs_address == sfbc_pkg::H_CMD && !wr_q) begin
                addr_q  <= avs_writedata[6:0];
                wdata_q <= avs_writedata[15:8];
                if (avs_writedata[sfbc_pkg::CMD_WRITE]) begin
                    wr_q <= 1'b1;
                end else begin
                    rd_q <= 1'b1;
                    st_q <= H_RD;
                end
            end
        end
    end

    // shaped: next bit goes out on each data clock rise
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            ctrl_q <= 2'h0;
            sh_q   <= 8'h00;
            scnt_q <= 4'h0;
            sdo_q  <= 1'b0;
        end else begin
            if (wr_hit && avs_address == sfbc_pkg::H_CTRL) begin
                ctrl_q <= avs_writedata[1:0];
            end
            if (wr_hit && avs_address == sfbc_pkg::H_STREAM) begin
                sh_q   <= avs_writedata[7:0];
                scnt_q <= 4'h8;
            end else if (ctrl_q[0] && dc_rise && scnt_q != 4'h0) begin
                sdo_q  <= sh_q[7];
                sh_q   <= {sh_q[6:0], 1'b0};
                scnt_q <= scnt_q - 4'h1;
            end
            if (!ctrl_q[0]) begin
                sdo_q <= ctrl_q[1];
            end
        end
    end

    // sticky events: a set in the clearing cycle wins
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            irq_st_q <= '0;
            irq_en_q <= '0;
            irq_q    <= 1'b0;
        end else begin
            irq_st_q <= (irq_st_q & ~((wr_hit && avs_address == sfbc_pkg::H_IRQ_CLR)
                        ? avs_writedata[sfbc_pkg::IRQ_W-1:0] : '0)) | ev;
            if (wr_hit && avs_address == sfbc_pkg::H_IRQ_EN) begin
                irq_en_q <= avs_writedata[sfbc_pkg::IRQ_W-1:0];
            end
            irq_q <= |(irq_st_q & irq_en_q);
        end
    end
endmodule

// ### src/sfbc_link_if.sv
// link between host controller and the synthesizer control device
`timescale 1ns/10ps
interface sfbc_link_if;
    logic       reg_wr;
    logic       reg_rd;
    logic [6:0] reg_addr;
    logic [7:0] reg_wdata;
    logic [7:0] reg_rdata;
    logic       reg_rvalid;
    logic       serial_data;
    logic       data_clock;
    logic       io_pin_five;
    logic       lock_detect;

    modport dev (
        input  reg_wr, reg_rd, reg_addr, reg_wdata, serial_data,
        output reg_rdata, reg_rvalid, data_clock, io_pin_five, lock_detect
    );
    modport host (
        output reg_wr, reg_rd, reg_addr, reg_wdata, serial_data,
        input  reg_rdata, reg_rvalid, data_clock, io_pin_five, lock_detect
    );
endinterface

// ### src/sfbc_pkg.sv
// shared constants for the synthesizer / bit-rate control link
package sfbc_pkg;
    localparam int          CLK_MHZ        = 20;
    // device register addresses
    localparam logic [6:0]  A_OPMODE       = 7'h01;
    localparam logic [6:0]  A_DATAMODE     = 7'h02;
    localparam logic [6:0]  A_BR_MSB       = 7'h03;
    localparam logic [6:0]  A_BR_LSB       = 7'h04;
    localparam logic [6:0]  A_FRF_MSB      = 7'h07;
    localparam logic [6:0]  A_FRF_MID      = 7'h08;
    localparam logic [6:0]  A_FRF_LSB      = 7'h09;
    localparam logic [6:0]  A_IOMAP2       = 7'h26;
    localparam logic [6:0]  A_FLAGS        = 7'h27;
    localparam logic [6:0]  A_REFSEL       = 7'h59;
    // field positions
    localparam int          OPM_SEQ_OFF    = 7;
    localparam int          OPM_MODE_LSB   = 2;
    localparam int          DM_CONT        = 6;
    localparam int          IOMAP_LOCK_LSB = 6;
    localparam logic [1:0]  LOCK_MAP_ON    = 2'h3;
    localparam logic [2:0]  REFERENCE_CLOCK_OUTPUT_OFF     = 3'h7;
    localparam int          FLAG_READY     = 7;
    localparam int          FLAG_LOCK      = 4;
    localparam int          REF_EXT_BIT    = 4;
    localparam int          FREQUENCY_STEP_EXP      = 19;
    // operating modes
    localparam logic [2:0]  MODE_SLEEP     = 3'h0;
    localparam logic [2:0]  MODE_FS        = 3'h2;
    localparam logic [2:0]  MODE_TX        = 3'h3;
    localparam logic [2:0]  MODE_RX        = 3'h4;
    // reset values
    localparam logic [7:0]  OPMODE_RST     = 8'h04;
    localparam logic [7:0]  DATAMODE_RST   = 8'h00;
    localparam logic [15:0] BR_RST         = 16'h1a0b;
    localparam logic [23:0] FRF_RST        = 24'h000000;
    localparam logic [7:0]  IOMAP2_RST     = 8'h00;
    localparam logic [7:0]  REFSEL_RST     = 8'h00;
    // analog settling figures in microseconds, then in clock cycles
    localparam int          OSC_START_US   = 250;
    localparam int          COARSE_US      = 50;
    localparam int          FINE_US        = 20;
    localparam int          LOCK_US        = 100;
    localparam int          OSC_START_CYC  = OSC_START_US * CLK_MHZ;
    localparam int          COARSE_CYC     = COARSE_US * CLK_MHZ;
    localparam int          FINE_CYC       = FINE_US * CLK_MHZ;
    localparam int          LOCK_CYC       = LOCK_US * CLK_MHZ;
    // host register byte offsets
    localparam logic [4:0]  H_CMD          = 5'h00;
    localparam logic [4:0]  H_STATUS       = 5'h04;
    localparam logic [4:0]  H_IRQ_ST       = 5'h08;
    localparam logic [4:0]  H_IRQ_CLR      = 5'h0c;
    localparam logic [4:0]  H_IRQ_EN       = 5'h10;
    localparam logic [4:0]  H_STREAM       = 5'h14;
    localparam logic [4:0]  H_CTRL         = 5'h18;
    localparam int          CMD_WRITE      = 16;
    localparam int          IRQ_W          = 5;
    localparam int          LOSS_FILT_CYC  = 64;
endpackage

// ### verification/sfbc_link_chk.sv
// link protocol and start-up assertions
`timescale 1ns/10ps
module sfbc_link_chk #(
    parameter int OSC_CYC  = sfbc_pkg::OSC_START_CYC,
    // earliest lock: oscillator, coarse, fine and lock spans back to back
    parameter int LOCK_MIN = sfbc_pkg::OSC_START_CYC + sfbc_pkg::COARSE_CYC
                             + sfbc_pkg::FINE_CYC + sfbc_pkg::LOCK_CYC
) (
    input logic clk,
    input logic rst,
    input logic reg_wr,
    input logic reg_rd,
    input logic reg_rvalid,
    input logic data_clock,
    input logic io_pin_five,
    input logic lock_detect
);
    logic [15:0] cyc_q;
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    // saturates so late checks never wrap
    always_ff @(posedge clk or posedge rst) begin
        if (rst) cyc_q <= '0;
        else if (cyc_q != 16'hffff) cyc_q <= cyc_q + 16'h1;
    end
    sequence s_rd_answer;
        reg_rd ##1 reg_rvalid;
    endsequence
    sequence s_data_bit_clock_half;
        data_clock [*8];
    endsequence
    a_rd_answer: assert property (reg_rd |-> s_rd_answer)
        else $error("read not answered");
    a_valid_cause: assert property ($rose(reg_rvalid) |-> $past(reg_rd))
        else $error("stray read answer");
    a_wr_pulse: assert property (reg_wr |=> !reg_wr)
        else $error("write strobe too long");
    a_rdwr_excl: assert property (!(reg_wr && reg_rd))
        else $error("read and write together");
    a_clk_wait: assert property (cyc_q < OSC_CYC |-> !io_pin_five)
        else $error("clock out before oscillator");
    a_clk_default: assert property (cyc_q == OSC_CYC + 4 |-> ##[0:16] $changed(io_pin_five))
        else $error("clock out not running");
    a_lock_late: assert property (cyc_q < LOCK_MIN |-> !lock_detect)
        else $error("lock too early");
    a_data_bit_clock_high: assert property ($rose(data_clock) |-> s_data_bit_clock_half)
        else $error("data clock high too short");
endmodule

// ### verification/test_synth_freq_bit_rate_value_ctrl.sv
// bench: both link ends driven through avalon
`timescale 1ns/10ps
module test_synth_freq_bit_rate_value_ctrl;
    logic clk = 0, rst = 1, rd = 0, wr = 0, wq, irq, ext, tick, txen, osc;
    logic ccal, fcal, sen, rxen, txb;
    logic [4:0]  adr = 0;
    logic [31:0] wd = 0, rdat, v;
    logic [23:0] freq, f;
    logic [7:0]  dv, b;
    int fails = 0, num_checks = 0, seed = 32'hd9ee, n, k;
    sfbc_link_if lnk ();
    always #25 clk = ~clk;
    // documented settling spans: 8400 cycles in all
    sfbc_dev u_sfbc_dev (
        .clk(clk), .rst(rst), .link(lnk), .synth_freq_q(freq), .osc_ready_q(osc),
        .coarse_cal_q(ccal), .fine_cal_q(fcal), .synth_en_q(sen), .rx_en_q(rxen),
        .tx_en_q(txen), .ext_ref_q(ext), .bit_tick_q(tick), .tx_bit_q(txb));
    sfbc_host u_sfbc_host (.clk(clk), .rst(rst), .link(lnk),
        .avs_address(adr), .avs_read(rd), .avs_write(wr), .avs_writedata(wd),
        .avs_readdata(rdat), .avs_waitrequest(wq), .irq_q(irq));
    sfbc_link_chk u_chk (.clk(clk), .rst(rst),
        .reg_wr(lnk.reg_wr), .reg_rd(lnk.reg_rd), .reg_rvalid(lnk.reg_rvalid),
        .data_clock(lnk.data_clock), .io_pin_five(lnk.io_pin_five),
        .lock_detect(lnk.lock_detect));
    task chk(input string nm, input logic [31:0] e, input logic [31:0] s);
        num_checks++;
        if (s !== e) begin
            $display("wrong value %s exp %h got %h", nm, e, s);
            fails++;
        end
    endtask
    // stream bits leave msb first
    function automatic logic bit_of(input logic [7:0] x, input int i);
        return x[7 - i];
    endfunction
    task bus(input logic [4:0] a, input logic w, input logic [31:0] d);
        @(posedge clk);
        adr <= a;
        wr <= w;
        rd <= !w;
        wd <= d;
        @(posedge clk);
        while (wq) @(posedge clk);
        v = rdat;
        wr <= 0;
        rd <= 0;
    endtask
    // link command, then poll busy; v ends as status
    task cmd(input logic w, input logic [6:0] a, input logic [7:0] d);
        bus(sfbc_pkg::H_CMD, 1, {15'h0, w, d, 1'b0, a});
        for (n = 0; n < 9; n++) begin
            bus(sfbc_pkg::H_STATUS, 0, 0);
            if (v[0] === 1'b0) break;
        end
    endtask
    task summarize;
        $display("checks %0d fails %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    initial begin
        #1000000;
        fails++;
        summarize();
    end
    initial begin
        repeat (3) @(posedge clk);
        rst <= 0;
        for (n = 0; n < 6000 && osc !== 1'b1; n++) @(posedge clk);
        chk("coarse_cal", 1, ccal);
        cmd(0, sfbc_pkg::A_BR_MSB, 0);
        chk("br_msb", 32'h1a, v[15:8]);
        bus(sfbc_pkg::H_IRQ_EN, 1, 1);
        f = 24'($random(seed));
        cmd(1, sfbc_pkg::A_FRF_MSB, f[23:16]);
        cmd(1, sfbc_pkg::A_FRF_MID, f[15:8]);
        chk("freq_hold", 0, freq);
        bus(sfbc_pkg::H_IRQ_CLR, 1, 1);
        repeat (2) @(posedge clk);
        chk("irq_idle", 0, irq);
        cmd(1, sfbc_pkg::A_FRF_LSB, f[7:0]);
        chk("freq", f, freq);
        chk("irq_on", 1, irq);
        bus(sfbc_pkg::H_IRQ_CLR, 1, 1);
        bus(sfbc_pkg::H_IRQ_ST, 0, 0);
        chk("irq_off", 0, {v[0], irq});
        bus(5'h1c, 0, 0);
        chk("unmapped", 0, v);
        cmd(1, sfbc_pkg::A_REFSEL, 8'h10);
        chk("ext_ref", 1, ext);
        // smallest legal divisor is 16
        dv = 8'd16 + 8'($random(seed) & 63);
        cmd(1, sfbc_pkg::A_BR_MSB, 0);
        cmd(1, sfbc_pkg::A_BR_LSB, dv);
        cmd(1, sfbc_pkg::A_IOMAP2, 8'hc0);
        cmd(1, sfbc_pkg::A_DATAMODE, 8'h41);
        cmd(1, sfbc_pkg::A_OPMODE, 8'h0c);
        for (n = 0; n < 4000 && txen !== 1'b1; n++) @(posedge clk);
        for (n = 0; n < 999 && tick !== 1'b1; n++) @(posedge clk);
        @(posedge clk);
        for (n = 1; n < 999 && tick !== 1'b1; n++) @(posedge clk);
        chk("bit_period", dv, n);
        // load the byte in a low phase so its first bit rides the next data clock
        bus(sfbc_pkg::H_CTRL, 1, 1);
        b = 8'($random(seed));
        while (lnk.data_clock !== 1'b1) @(posedge clk);
        while (lnk.data_clock !== 1'b0) @(posedge clk);
        bus(sfbc_pkg::H_STREAM, 1, {24'h0, b});
        for (k = 0; k < 8; k++) begin
            while (lnk.data_clock !== 1'b1) @(posedge clk);
            while (lnk.data_clock !== 1'b0) @(posedge clk);
            chk("tx_bit", bit_of(b, k), txb);
        end
        // leave shaping inside the low phase, then the async level passes
        cmd(1, sfbc_pkg::A_DATAMODE, 8'h40);
        bus(sfbc_pkg::H_CTRL, 1, 2);
        repeat (6) @(posedge clk);
        chk("async_bit", 1, txb);
        bus(sfbc_pkg::H_STREAM, 0, 0);
        chk("stream_left", 0, v);
        bus(sfbc_pkg::H_IRQ_ST, 0, 0);
        chk("stream_irq", 1, v[4]);
        bus(sfbc_pkg::H_STATUS, 0, 0);
        chk("host_watch", 2'b11, v[17:16]);
        chk("seq_state", 4'b1000, {sen, rxen, fcal, ccal});
        chk("lock_tx", 2'b11, {lnk.lock_detect, txen});
        summarize();
    end
endmodule
